// [logic/wdc_pkg.sv]
// constants, types and register map of the watchdog command and timeout block
// How it works
// - 8-bit write-only command port, two keys
// - clear key resets counter to zero
// - disable key stops counting once enable cleared
// - timeout interrupt after selected detection period
// - missed clear lets counter overflow, raising interrupt
// - reset-output option forwards timeout as reset
// - counting starts enabled straight out of reset
// - sleep or stop holds counter at zero
// - released bus does not stop counting
// - idle mode counts only if idle-run set
package wdc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [5:0] MODE_IDX = 6'h00;
  localparam logic [5:0] CMD_IDX = 6'h01;
  localparam logic [5:0] IRQ_STATUS_IDX = 6'h02;
  localparam logic [5:0] IRQ_CLEAR_IDX = 6'h03;
  localparam logic [5:0] IRQ_ENABLE_IDX = 6'h04;
  localparam logic [5:0] COUNT_IDX = 6'h05;
  localparam logic [5:0] STATE_IDX = 6'h06;
  localparam int unsigned WORD_LSB = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // mode register fields
  localparam int unsigned MODE_ENABLE_BIT = 7;
  localparam int unsigned MODE_PERIOD_LSB = 5;
  localparam int unsigned MODE_IDLE_RUN_BIT = 2;
  localparam int unsigned MODE_RESET_OUT_BIT = 1;
  localparam logic [7:0] MODE_RESET = 8'h80;

  // command keys
  localparam logic [7:0] KEY_DISABLE = 8'hb1;
  localparam logic [7:0] KEY_CLEAR = 8'h4e;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt layout
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_TIMEOUT_BIT = 0;
  localparam int unsigned IRQ_BADKEY_BIT = 1;
  localparam logic [1:0] IRQ_ENABLE_RESET = 2'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // counter: period is 2^(base + step * period_select) clocks
  localparam int unsigned CNT_W = 23;
  localparam int unsigned BASE_EXP_DEFAULT = 16;
  localparam logic [4:0] PERIOD_STEP = 5'h02;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_IDLE_HOLD = 2'b01,
    ST_LOW_POWER = 2'b10,
    ST_OFF = 2'b11
  } wdc_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [SEL_W-1:0] sel;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
  } wdc_wb_req_t;

  typedef struct packed {
    logic enable;
    logic [1:0] period;
    logic idle_run;
    logic reset_out;
  } wdc_mode_t;

endpackage : wdc_pkg

// [logic/wdc_sticky.sv]
// sticky event flags, a set in the same cycle as a clear wins
`timescale 1ns/100ps
module wdc_sticky #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  always_comb begin
    flags_d = (flags_q & ~clr) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule : wdc_sticky

// [logic/wdc_counter.sv]
// binary timeout counter with clear, hold at zero and terminal count
`timescale 1ns/100ps
module wdc_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic hold_zero,
  input wire logic count_en,
  input wire logic [wdc_pkg::CNT_W-1:0] terminal,
  output logic [wdc_pkg::CNT_W-1:0] count,
  output logic overflow
);

  logic [wdc_pkg::CNT_W-1:0] count_q;
  logic [wdc_pkg::CNT_W-1:0] count_d;
  logic overflow_q;
  logic overflow_d;

  always_comb begin
    count_d = count_q;
    overflow_d = 1'b0;
    if (clear || hold_zero) begin
      count_d = '0;
    end else if (count_en) begin
      if (count_q >= terminal) begin
        count_d = '0;
        overflow_d = 1'b1;
      end else begin
        count_d = count_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      overflow_q <= 1'b0;
    end else begin
      count_q <= count_d;
      overflow_q <= overflow_d;
    end
  end

  assign count = count_q;
  assign overflow = overflow_q;

endmodule : wdc_counter

// [logic/wdc_top.sv]
// watchdog command and timeout block with its wishbone register slave
`timescale 1ns/100ps
module wdc_top #(
  parameter int unsigned BASE_EXP = wdc_pkg::BASE_EXP_DEFAULT
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [wdc_pkg::SEL_W-1:0] WB_SEL,
  input wire logic [wdc_pkg::ADDR_W-1:0] WB_ADR,
  input wire logic [wdc_pkg::DATA_W-1:0] WB_DAT_W,
  output logic [wdc_pkg::DATA_W-1:0] WB_DAT_R,
  output logic WB_ACK,
  input wire logic SLEEP_STOP,
  input wire logic IDLE_MODE,
  input wire logic BUS_RELEASE_ACK_N,
  output logic TIMEOUT_INTERRUPT,
  output logic RESET_REQ
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus request and decode

  wdc_pkg::wdc_wb_req_t req;
  logic ack_q;
  logic ack_d;
  logic [wdc_pkg::DATA_W-1:0] rdata_q;
  logic [wdc_pkg::DATA_W-1:0] rdata_d;
  logic [5:0] word_idx;
  logic lane0;
  logic wr_fire;
  logic wr_mode;
  logic wr_cmd;
  logic wr_irq_clear;
  logic wr_irq_enable;
  logic [7:0] wr_byte;

  assign req.cyc = WB_CYC;
  assign req.stb = WB_STB;
  assign req.we = WB_WE;
  assign req.sel = WB_SEL;
  assign req.adr = WB_ADR;
  assign req.dat = WB_DAT_W;

  assign word_idx = req.adr[wdc_pkg::ADDR_W-1:wdc_pkg::WORD_LSB];
  assign lane0 = req.sel[0];
  assign wr_byte = req.dat[7:0];

  // a write lands on the edge at which the master sees ack
  assign wr_fire = req.cyc && req.stb && req.we && ack_q && lane0;
  assign wr_mode = wr_fire && (word_idx == wdc_pkg::MODE_IDX);
  assign wr_cmd = wr_fire && (word_idx == wdc_pkg::CMD_IDX);
  assign wr_irq_clear = wr_fire && (word_idx == wdc_pkg::IRQ_CLEAR_IDX);
  assign wr_irq_enable = wr_fire && (word_idx == wdc_pkg::IRQ_ENABLE_IDX);

  ////////////////////////////////////////////////////////////////////////////////
  // command decode

  logic key_clear;
  logic key_disable;
  logic key_bad;

  always_comb begin
    key_clear = 1'b0;
    key_disable = 1'b0;
    key_bad = 1'b0;
    if (wr_cmd) begin
      if (wr_byte == wdc_pkg::KEY_CLEAR) begin
        key_clear = 1'b1;
      end else if (wr_byte == wdc_pkg::KEY_DISABLE) begin
        key_disable = 1'b1;
      end else begin
        key_bad = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode register and run state

  wdc_pkg::wdc_mode_t mode_q;
  wdc_pkg::wdc_mode_t mode_d;
  logic running_q;
  logic running_d;

  always_comb begin
    mode_d = mode_q;
    running_d = running_q;
    if (wr_mode) begin
      mode_d.enable = wr_byte[wdc_pkg::MODE_ENABLE_BIT];
      mode_d.period = wr_byte[wdc_pkg::MODE_PERIOD_LSB +: 2];
      mode_d.idle_run = wr_byte[wdc_pkg::MODE_IDLE_RUN_BIT];
      mode_d.reset_out = wr_byte[wdc_pkg::MODE_RESET_OUT_BIT];
      if (wr_byte[wdc_pkg::MODE_ENABLE_BIT]) begin
        running_d = 1'b1;
      end
    end
    // the disable key only counts once the enable bit is already low
    if (key_disable && !mode_q.enable) begin
      running_d = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q.enable <= wdc_pkg::MODE_RESET[wdc_pkg::MODE_ENABLE_BIT];
      mode_q.period <= wdc_pkg::MODE_RESET[wdc_pkg::MODE_PERIOD_LSB +: 2];
      mode_q.idle_run <= wdc_pkg::MODE_RESET[wdc_pkg::MODE_IDLE_RUN_BIT];
      mode_q.reset_out <= wdc_pkg::MODE_RESET[wdc_pkg::MODE_RESET_OUT_BIT];
      running_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      running_q <= running_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power state decides whether the counter runs

  wdc_pkg::wdc_state_t state_now;
  wdc_pkg::wdc_state_t state_q;
  logic count_en;
  logic hold_zero;

  always_comb begin
    // sleep zeroes the counter even while it is switched off
    if (SLEEP_STOP) begin
      state_now = wdc_pkg::ST_LOW_POWER;
    end else if (!running_q) begin
      state_now = wdc_pkg::ST_OFF;
    end else if (IDLE_MODE && !mode_q.idle_run) begin
      state_now = wdc_pkg::ST_IDLE_HOLD;
    end else begin
      state_now = wdc_pkg::ST_RUN;
    end
  end

  always_comb begin
    count_en = 1'b0;
    hold_zero = 1'b0;
    unique case (state_now)
      wdc_pkg::ST_RUN: begin
        // bus release does not gate counting
        count_en = 1'b1;
      end
      wdc_pkg::ST_IDLE_HOLD: begin
        count_en = 1'b0;
      end
      wdc_pkg::ST_LOW_POWER: begin
        hold_zero = 1'b1;
      end
      wdc_pkg::ST_OFF: begin
        count_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= wdc_pkg::ST_RUN;
    end else begin
      state_q <= state_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // detection period and counter

  logic [4:0] period_exp;
  logic [wdc_pkg::CNT_W-1:0] terminal;
  logic [wdc_pkg::CNT_W-1:0] count;
  logic overflow;

  always_comb begin
    // a count already past a shorter new period wraps on the next counting edge
    period_exp = 5'(BASE_EXP) + ((5'(mode_q.period)) * wdc_pkg::PERIOD_STEP);
    terminal = (wdc_pkg::CNT_W'(1) << period_exp) - wdc_pkg::CNT_W'(1);
  end

  // clear and hold-at-zero beat counting, so a late clear never loses to a wrap
  wdc_counter u_counter (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(key_clear),
    .hold_zero(hold_zero),
    .count_en(count_en),
    .terminal(terminal),
    .count(count),
    .overflow(overflow)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // reset request output

  logic reset_req_q;
  logic reset_req_d;

  always_comb begin
    // one-cycle pulse, the edge after the counter wraps
    reset_req_d = overflow && mode_q.reset_out;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= reset_req_d;
    end
  end

  assign RESET_REQ = reset_req_q;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status, enable and clear

  logic [wdc_pkg::IRQ_W-1:0] irq_set;
  logic [wdc_pkg::IRQ_W-1:0] irq_clr;
  logic [wdc_pkg::IRQ_W-1:0] irq_status;
  logic [wdc_pkg::IRQ_W-1:0] irq_enable_q;
  logic [wdc_pkg::IRQ_W-1:0] irq_enable_d;

  always_comb begin
    // stray command codes raise the bad-key flag so a runaway can be spotted
    irq_set = '0;
    irq_set[wdc_pkg::IRQ_TIMEOUT_BIT] = overflow;
    irq_set[wdc_pkg::IRQ_BADKEY_BIT] = key_bad;
    irq_clr = wr_irq_clear ? wr_byte[wdc_pkg::IRQ_W-1:0] : '0;
    irq_enable_d = wr_irq_enable ? wr_byte[wdc_pkg::IRQ_W-1:0] : irq_enable_q;
  end

  wdc_sticky #(
    .WIDTH(wdc_pkg::IRQ_W)
  ) u_irq_status (
    .clk(MCLK),
    .rst_n(RST_N),
    .set(irq_set),
    .clr(irq_clr),
    .flags(irq_status)
  );

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_enable_q <= wdc_pkg::IRQ_ENABLE_RESET;
    end else begin
      irq_enable_q <= irq_enable_d;
    end
  end

  assign TIMEOUT_INTERRUPT = |(irq_status & irq_enable_q);

  ////////////////////////////////////////////////////////////////////////////////
  // read data and acknowledge

  logic [7:0] mode_byte;

  always_comb begin
    mode_byte = '0;
    mode_byte[wdc_pkg::MODE_ENABLE_BIT] = mode_q.enable;
    mode_byte[wdc_pkg::MODE_PERIOD_LSB +: 2] = mode_q.period;
    mode_byte[wdc_pkg::MODE_IDLE_RUN_BIT] = mode_q.idle_run;
    mode_byte[wdc_pkg::MODE_RESET_OUT_BIT] = mode_q.reset_out;
  end

  always_comb begin
    // a held strobe gets a fresh ack every other cycle
    ack_d = req.cyc && req.stb && !ack_q;
    rdata_d = rdata_q;
    if (ack_d) begin
      rdata_d = '0;
      if (!req.we) begin
        unique case (word_idx)
          wdc_pkg::MODE_IDX: rdata_d[7:0] = mode_byte;
          wdc_pkg::IRQ_STATUS_IDX: rdata_d[wdc_pkg::IRQ_W-1:0] = irq_status;
          wdc_pkg::IRQ_ENABLE_IDX: rdata_d[wdc_pkg::IRQ_W-1:0] = irq_enable_q;
          wdc_pkg::COUNT_IDX: rdata_d[wdc_pkg::CNT_W-1:0] = count;
          wdc_pkg::STATE_IDX: rdata_d[3:0] = {~BUS_RELEASE_ACK_N, running_q, state_q};
          default: rdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // read data stay until the next access is acknowledged
  assign WB_ACK = ack_q;
  assign WB_DAT_R = rdata_q;

endmodule : wdc_top

// [verification/wdc_props.sv]
// port checker of the watchdog command and timeout block
`timescale 1ns/100ps
module wdc_props #(
  parameter int unsigned BASE_EXP = wdc_pkg::BASE_EXP_DEFAULT
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [wdc_pkg::SEL_W-1:0] WB_SEL,
  input wire logic [wdc_pkg::ADDR_W-1:0] WB_ADR,
  input wire logic [wdc_pkg::DATA_W-1:0] WB_DAT_W,
  input wire logic [wdc_pkg::DATA_W-1:0] WB_DAT_R,
  input wire logic WB_ACK,
  input wire logic SLEEP_STOP,
  input wire logic IDLE_MODE,
  input wire logic BUS_RELEASE_ACK_N,
  input wire logic TIMEOUT_INTERRUPT,
  input wire logic RESET_REQ
);
  int unsigned since_q;
  logic quiet_q;
  logic rd;
  logic wack;
  assign rd = WB_CYC && WB_STB && !WB_WE && !WB_ACK;
  assign wack = WB_ACK && WB_WE;
  // edges since reset release, and whether any write landed meanwhile
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      since_q <= 0;
      quiet_q <= 1'b1;
    end else begin
      since_q <= since_q + 1;
      if (wack) quiet_q <= 1'b0;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////////
  chk_ack_once: assert property (WB_ACK |=> !WB_ACK)
    else $error("ack held longer than one cycle");
  chk_ack_latency: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK)
    else $error("ack missing one cycle after request");
  chk_ack_idle: assert property (!WB_CYC |=> !WB_ACK)
    else $error("ack without request");
  chk_cmd_reads_zero: assert property (rd && (WB_ADR[7:2] == wdc_pkg::CMD_IDX ||
    WB_ADR[7:2] > wdc_pkg::STATE_IDX) |=> WB_DAT_R == '0)
    else $error("write-only or unmapped read not zero");
  chk_sleep_zero: assert property (rd && WB_ADR[7:2] == wdc_pkg::COUNT_IDX &&
    SLEEP_STOP && $past(SLEEP_STOP) |=> WB_DAT_R == '0)
    else $error("counter not zero in sleep");
  chk_first_timeout: assert property (quiet_q && since_q == 2**BASE_EXP |->
    !TIMEOUT_INTERRUPT ##1 TIMEOUT_INTERRUPT)
    else $error("first timeout at wrong edge");
  chk_rstreq_pulse: assert property (RESET_REQ |=> !RESET_REQ)
    else $error("reset request longer than one cycle");
  chk_irq_fall: assert property ($fell(TIMEOUT_INTERRUPT) |-> $past(wack))
    else $error("interrupt dropped without a write");
  cover property ($rose(TIMEOUT_INTERRUPT));
  cover property (RESET_REQ);
  cover property (rd && SLEEP_STOP);
endmodule : wdc_props

// [verification/tb.sv]
// self-checking bench of the watchdog command and timeout block
`timescale 1ns/100ps
module tb;
  localparam int E = 4;
  logic mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, irq, rreq;
  logic slp = 0, idl = 0, reln = 1;
  logic [3:0] sel = 4'hf;
  logic [7:0] adr = 8'h00, d;
  logic [31:0] dw = 32'h0, dr, rd, a;
  int mismatches = 0, samples_checked = 0, cycles = 0, seed = 12, n, mode_m;
  always #2.5 mclk = ~mclk;
  wdc_top #(.BASE_EXP(E)) wdc_top_i (.MCLK(mclk), .RST_N(rst_n), .WB_CYC(cyc), .WB_STB(stb),
    .WB_WE(we), .WB_SEL(sel), .WB_ADR(adr), .WB_DAT_W(dw), .WB_DAT_R(dr), .WB_ACK(ack),
    .SLEEP_STOP(slp), .IDLE_MODE(idl), .BUS_RELEASE_ACK_N(reln), .TIMEOUT_INTERRUPT(irq),
    .RESET_REQ(rreq));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // one classic wishbone access, read data left in rd
  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] v);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dw <= {24'h0, v};
    do @(posedge mclk); while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // behavioural model of the counter and the timeout flag, fed by the bench's own stimulus
  int m_cnt = 0, m_snap = 0, m_per = 0;
  bit m_run = 1'b1, m_en = 1'b1, m_irun = 1'b0, m_ovf = 1'b0, m_st = 1'b0, m_stsnap = 1'b0;
  wire m_fire = cyc && stb && we && ack && sel[0];
  wire [5:0] m_idx = adr[7:2];
  wire m_clr = m_fire && m_idx == wdc_pkg::CMD_IDX && dw[7:0] == wdc_pkg::KEY_CLEAR;
  wire m_go = m_run && !(idl && !m_irun) && !slp && !m_clr;
  wire m_top = m_cnt >= (1 << (E + 2 * m_per)) - 1;
  always @(posedge mclk) begin
    if (rst_n) begin
      if (cyc && stb && !ack) begin
        m_snap <= m_cnt;
        m_stsnap <= m_st;
      end
      m_st <= m_ovf || (m_st && !(m_fire && m_idx == wdc_pkg::IRQ_CLEAR_IDX && dw[0]));
      m_ovf <= m_go && m_top;
      if (m_clr || slp || (m_go && m_top)) begin
        m_cnt <= 0;
      end else if (m_go) begin
        m_cnt <= m_cnt + 1;
      end
      if (m_fire && m_idx == wdc_pkg::MODE_IDX) begin
        m_en <= dw[wdc_pkg::MODE_ENABLE_BIT];
        m_per <= int'(dw[wdc_pkg::MODE_PERIOD_LSB +: 2]);
        m_irun <= dw[wdc_pkg::MODE_IDLE_RUN_BIT];
        if (dw[wdc_pkg::MODE_ENABLE_BIT]) begin
          m_run <= 1'b1;
        end
      end
      if (m_fire && m_idx == wdc_pkg::CMD_IDX && dw[7:0] == wdc_pkg::KEY_DISABLE && !m_en) begin
        m_run <= 1'b0;
      end
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (20) @(posedge mclk);
    check("irq", 32'(irq), 1);
    wb(0, wdc_pkg::IRQ_STATUS_IDX, 0);
    check("status", rd, 1);
    check("status model", 32'(rd[0]), 32'(m_stsnap));
    mode_m = 128;
    wb(0, wdc_pkg::MODE_IDX, 0);
    check("mode", rd, mode_m);
    wb(0, wdc_pkg::CMD_IDX, 0);
    check("cmd", rd, 0);
    wb(1, 6'h07, 8'hff);
    wb(0, 6'h07, 0);
    check("unmapped", rd, 0);
    wb(1, wdc_pkg::IRQ_ENABLE_IDX, 0);
    @(posedge mclk);
    check("masked", 32'(irq), 0);
    wb(1, wdc_pkg::IRQ_ENABLE_IDX, 1);
    @(posedge mclk);
    check("unmasked", 32'(irq), 1);
    sel <= 4'he;
    wb(1, wdc_pkg::IRQ_ENABLE_IDX, 0);
    sel <= 4'hf;
    wb(0, wdc_pkg::IRQ_ENABLE_IDX, 0);
    check("lane off", rd, 1);
    wb(1, wdc_pkg::MODE_IDX, 8'he0);
    wb(1, wdc_pkg::CMD_IDX, 8'h4e);
    wb(1, wdc_pkg::IRQ_CLEAR_IDX, 1);
    @(posedge mclk);
    check("cleared", 32'(irq), 0);
    wb(0, wdc_pkg::COUNT_IDX, 0);
    check("count clr", 32'(rd < 8), 1);
    check("count model", rd, m_snap);
    repeat (20) @(posedge mclk);
    for (int k = 0; k < 3; k++) begin
      do d = 8'($random(seed)); while (d == 8'h4e || d == 8'hb1);
      wb(1, wdc_pkg::CMD_IDX, d);
    end
    wb(0, wdc_pkg::COUNT_IDX, 0);
    check("count kept", 32'(rd >= 20), 1);
    check("count model", rd, m_snap);
    wb(1, wdc_pkg::CMD_IDX, 8'hb1);
    wb(0, wdc_pkg::STATE_IDX, 0);
    check("running", 32'(rd[2]), 1);
    wb(1, wdc_pkg::MODE_IDX, 8'h00);
    wb(1, wdc_pkg::CMD_IDX, 8'hb1);
    wb(0, wdc_pkg::STATE_IDX, 0);
    check("stopped", 32'(rd[2]), 0);
    wb(0, wdc_pkg::COUNT_IDX, 0);
    a = rd;
    repeat (10) @(posedge mclk);
    wb(0, wdc_pkg::COUNT_IDX, 0);
    check("count held", rd, a);
    check("count model", rd, m_snap);
    wb(1, wdc_pkg::MODE_IDX, 8'he0);
    idl <= 1'b1;
    wb(0, wdc_pkg::COUNT_IDX, 0);
    a = rd;
    repeat (8) @(posedge mclk);
    wb(0, wdc_pkg::COUNT_IDX, 0);
    check("idle hold", rd, a);
    check("count model", rd, m_snap);
    wb(1, wdc_pkg::MODE_IDX, 8'he4);
    repeat (8) @(posedge mclk);
    wb(0, wdc_pkg::COUNT_IDX, 0);
    check("idle run", 32'(rd > a), 1);
    check("count model", rd, m_snap);
    idl <= 1'b0;
    reln <= 1'b0;
    a = rd;
    repeat (8) @(posedge mclk);
    wb(0, wdc_pkg::COUNT_IDX, 0);
    check("released", 32'(rd > a), 1);
    check("count model", rd, m_snap);
    reln <= 1'b1;
    slp <= 1'b1;
    repeat (3) @(posedge mclk);
    wb(0, wdc_pkg::COUNT_IDX, 0);
    check("sleep", rd, 0);
    check("count model", rd, m_snap);
    slp <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      mode_m = 128 + p * 32;
      wb(1, wdc_pkg::MODE_IDX, 8'(mode_m));
      wb(0, wdc_pkg::MODE_IDX, 0);
      check("mode", rd, mode_m);
      wb(1, wdc_pkg::CMD_IDX, 8'h4e);
      wb(1, wdc_pkg::IRQ_CLEAR_IDX, 1);
      repeat ((1 << (E + 2 * p)) - 10) @(posedge mclk);
      wb(0, wdc_pkg::IRQ_STATUS_IDX, 0);
      check("early", 32'(rd[0]), 0);
      check("early model", 32'(rd[0]), 32'(m_stsnap));
      repeat (12) @(posedge mclk);
      wb(0, wdc_pkg::IRQ_STATUS_IDX, 0);
      check("timeout", 32'(rd[0]), 1);
      check("timeout model", 32'(rd[0]), 32'(m_stsnap));
    end
    // clear first so the shorter period cannot run out before the restart
    wb(1, wdc_pkg::CMD_IDX, 8'h4e);
    wb(1, wdc_pkg::MODE_IDX, 8'h82);
    wb(1, wdc_pkg::CMD_IDX, 8'h4e);
    n = 0;
    while (rreq !== 1'b1) begin
      @(posedge mclk);
      n++;
    end
    check("reset req", n, (1 << E) + 2);
    give_verdict();
  end
endmodule : tb
bind wdc_top wdc_props #(.BASE_EXP(BASE_EXP)) wdc_props_i (.MCLK(MCLK), .RST_N(RST_N),
  .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_SEL(WB_SEL), .WB_ADR(WB_ADR),
  .WB_DAT_W(WB_DAT_W), .WB_DAT_R(WB_DAT_R), .WB_ACK(WB_ACK), .SLEEP_STOP(SLEEP_STOP),
  .IDLE_MODE(IDLE_MODE), .BUS_RELEASE_ACK_N(BUS_RELEASE_ACK_N),
  .TIMEOUT_INTERRUPT(TIMEOUT_INTERRUPT), .RESET_REQ(RESET_REQ));
